// >>> flash_ctl_pkg.sv
// Shared constants, types and helpers for the on-chip flash access block.
// Assumes a 16-bit CPU bus whose byte lanes follow even-upper, odd-lower order.
package flash_ctl_pkg;

  // ----------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] CTRL_ADDR       = 16'hFF80;
  localparam logic [15:0] BLOCK_SEL_ADDR  = 16'hFF82;
  localparam logic [15:0] MODE_CTRL_ADDR  = 16'hFFC5;
  localparam logic [15:0] ROM_TOP         = 16'hEFFF;
  localparam logic [7:0]  CTRL_RESET      = 8'h80;
  localparam logic [7:0]  BLOCK_SEL_RESET = 8'h00;
  localparam logic [7:0]  RESERVED_BYTE   = 8'hFF;
  localparam logic [15:0] RESERVED_WORD   = 16'hFFFF;
  localparam logic [7:0]  CTRL_WMASK      = 8'h4F;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_VPP_BIT    = 7;
  localparam int CTRL_SWPROT_BIT = 6;
  localparam int CTRL_ERR_BIT    = 5;
  localparam int CTRL_EV_BIT     = 3;
  localparam int CTRL_PV_BIT     = 2;
  localparam int CTRL_E_BIT      = 1;
  localparam int CTRL_P_BIT      = 0;
  localparam int MODE_CONTROL_REGISTER_EXPANDED_MODE_ENABLE_BIT   = 7;
  localparam logic [4:0] MODE_CONTROL_REGISTER_FIXED = 5'b11001;

  // ----------------------------------------------------------------
  // Program unit and boot serial link
  // ----------------------------------------------------------------
  localparam int PROG_UNIT_BYTES = 32;
  localparam int BUF_WORDS       = PROG_UNIT_BYTES / 2;
  localparam int BAUD_W          = 16;
  localparam int SYNC_LOW_LOG2   = 3;
  localparam logic [7:0] BOOT_ACK_BYTE = 8'h00;

  typedef enum {MODE_EXP_NOROM, MODE_EXP_ROM, MODE_SINGLE} op_mode_e;
  typedef enum {RG_ROM, RG_REG, RG_MODE_CONTROL_REGISTER, RG_RESERVED, RG_EXTERNAL} region_e;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        rd;
    logic        wr;
    logic        byte_acc;
  } cpu_req_s;

  typedef struct packed {
    logic prog;
    logic erase;
    logic prog_verify;
    logic erase_verify;
  } flash_op_s;

  // Even address on the upper lane, odd on the lower
  function automatic logic [15:0] to_lane(input logic [15:0] a, input logic [7:0] b);
    to_lane = a[0] ? {8'h00, b} : {b, 8'h00};
  endfunction

  function automatic logic [7:0] from_lane(input logic [15:0] a, input logic [15:0] w);
    from_lane = a[0] ? w[7:0] : w[15:8];
  endfunction

endpackage

// >>> flash_page_buffer.sv
// Holds one 32-byte program unit as sixteen 16-bit words with byte enables.
// Assumes one writer (CPU side) and one reader (array side) on the same clock.
`timescale 1ns/1ps
module flash_page_buffer
  import flash_ctl_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        wr_en,
  input  wire logic [3:0]  wr_idx,
  input  wire logic [1:0]  wr_be,
  input  wire logic [15:0] wr_data,
  input  wire logic [3:0]  rd_idx,
  output logic      [15:0] rd_data
);

  logic [15:0] mem [BUF_WORDS];

  // ----------------------------------------------------------------
  // Byte-lane writes, registered read
  // ----------------------------------------------------------------
  // No reset: contents are don't-care until software loads a unit
  always_ff @(posedge clock) begin
    if (wr_en && wr_be[1]) begin
      mem[wr_idx][15:8] <= wr_data[15:8];
    end
    if (wr_en && wr_be[0]) begin
      mem[wr_idx][7:0] <= wr_data[7:0];
    end
  end

  always_ff @(posedge clock) begin
    rd_data <= mem[rd_idx];
  end

endmodule

// >>> serial_boot_link.sv
// Boot serial link: measures the host bit time and answers with one byte.
// Assumes the host first sends a sync byte whose low time spans eight bit times.
`timescale 1ns/1ps
module serial_boot_link
  import flash_ctl_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              enable,
  input  wire logic              rx,
  output logic                   tx,
  output logic [BAUD_W-1:0]      bit_period,
  output logic                   locked
);

  typedef enum {B_WAIT, B_MEASURE, B_ACK, B_DONE} link_state_e;

  link_state_e       state_q;
  logic [BAUD_W-1:0] cnt_q;
  logic [BAUD_W-1:0] tcnt_q;
  logic [9:0]        sh_q;
  logic [3:0]        bits_q;

  assign tx         = sh_q[0];
  assign bit_period = cnt_q;
  assign locked     = (state_q == B_ACK) || (state_q == B_DONE);

  // ----------------------------------------------------------------
  // Bit-rate measurement and answer
  // ----------------------------------------------------------------
  // Saturating count so a stuck-low line cannot wrap to a tiny period
  always_ff @(posedge clock) begin
    if (!rst_n || !enable) begin
      state_q <= B_WAIT;
      cnt_q   <= '0;
      tcnt_q  <= '0;
      sh_q    <= '1;
      bits_q  <= '0;
    end else begin
      case (state_q)
        B_WAIT: begin
          if (!rx) begin
            state_q <= B_MEASURE;
            cnt_q   <= BAUD_W'(1);
          end
        end
        B_MEASURE: begin
          if (!rx) begin
            if (cnt_q != '1) cnt_q <= cnt_q + BAUD_W'(1);
          end else begin
            cnt_q   <= (cnt_q >> SYNC_LOW_LOG2) == '0 ? BAUD_W'(1) : cnt_q >> SYNC_LOW_LOG2;
            sh_q    <= {1'b1, BOOT_ACK_BYTE, 1'b0};
            tcnt_q  <= '0;
            bits_q  <= '0;
            state_q <= B_ACK;
          end
        end
        B_ACK: begin
          if (tcnt_q == cnt_q - BAUD_W'(1)) begin
            tcnt_q <= '0;
            sh_q   <= {1'b1, sh_q[9:1]};
            bits_q <= bits_q + 4'd1;
            if (bits_q == 4'd9) state_q <= B_DONE;
          end else begin
            tcnt_q <= tcnt_q + BAUD_W'(1);
          end
        end
        default: state_q <= state_q;
      endcase
    end
  end

  property p_period_nonzero;
    @(posedge clock) disable iff (!rst_n) locked |-> bit_period != '0;
  endproperty
  a_period_nonzero: assert property (p_period_nonzero) else $error("locked with zero bit period");

  property p_tx_idle_high;
    @(posedge clock) disable iff (!rst_n) (state_q == B_WAIT) |-> tx;
  endproperty
  a_tx_idle_high: assert property (p_tx_idle_high) else $error("serial tx not idle high");

endmodule

// >>> flash_rom_access.sv
// Access and control logic of the on-chip flash ROM: bus decode, control window,
// protection and the boot serial link. Assumes the flash array answers reads in
// the same cycle and a comparator reports high voltage on the programming pin.
`timescale 1ns/1ps

module flash_rom_access
  import flash_ctl_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire cpu_req_s          cpu_req,
  output logic      [15:0]       cpu_rdata,
  output logic                   cpu_ready,
  output logic                   cpu_refused,
  output logic                   ext_access,
  input  wire logic              mode_pin_upper,
  input  wire logic              mode_pin_lower,
  input  wire logic              aux_mode_pin_2,
  input  wire logic              aux_mode_pin_1,
  input  wire logic              aux_mode_pin_0,
  input  wire logic              program_voltage_pin,
  input  wire logic              hw_protect,
  output logic      [15:0]       array_addr,
  input  wire logic [15:0]       array_rdata,
  output flash_op_s              flash_op,
  output logic      [7:0]        erase_blocks,
  output logic      [10:0]       prog_row,
  input  wire logic [3:0]        buf_rd_idx,
  output logic      [15:0]       buf_rd_data,
  output logic                   rom_enabled,
  output logic                   boot_mode,
  input  wire logic              serial1_rx_pin,
  output logic                   serial1_tx_pin,
  output logic                   baud_locked
);

  typedef enum {S_IDLE, S_DATA} bus_state_e;

  bus_state_e  state_q;
  op_mode_e    mode_q;
  region_e     region_q;
  region_e     region_d;
  logic [1:0]  pins_q;
  logic        boot_q;
  logic        expanded_mode_enable_q;
  logic        vpp_q;
  logic [7:0]  ctrl_q;
  logic [7:0]  ctrl_nxt;
  logic [7:0]  ctrl_rd;
  logic [7:0]  blk_q;
  logic [7:0]  blk_nxt;
  logic [7:0]  mode_control_register_rd;
  logic [7:0]  wbyte;
  logic [15:0] rdata_d;
  logic        take;
  logic        bad_align;
  logic        expanded;
  logic        ctrl_wr;
  logic        blk_wr;
  logic        err_set;
  logic        protect;
  logic        buf_wr;
  logic [1:0]  buf_be;
  logic        refused_q;
  flash_op_s   op_q;
  logic [7:0]  erase_blk_q;
  logic [10:0] row_q;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic op_mode_e decode_mode(input logic [1:0] p);
    case (p)
      2'b01:   decode_mode = MODE_EXP_NOROM;
      2'b10:   decode_mode = MODE_EXP_ROM;
      default: decode_mode = MODE_SINGLE;
    endcase
  endfunction

  function automatic region_e decode_region(input logic [15:0] a, input op_mode_e m,
                                            input logic expd, input logic vpp);
    if (a == CTRL_ADDR || a == BLOCK_SEL_ADDR) begin
      if (m == MODE_EXP_NOROM) decode_region = vpp ? RG_RESERVED : RG_EXTERNAL;
      else if (expd) decode_region = vpp ? RG_REG : RG_EXTERNAL;
      else decode_region = vpp ? RG_REG : RG_RESERVED;
    end else if (a == MODE_CTRL_ADDR) begin
      decode_region = RG_MODE_CONTROL_REGISTER;
    end else if (a <= ROM_TOP && m != MODE_EXP_NOROM) begin
      decode_region = RG_ROM;
    end else begin
      decode_region = expd ? RG_EXTERNAL : RG_RESERVED;
    end
  endfunction

  function automatic logic one_hot8(input logic [7:0] v);
    one_hot8 = (v != 8'h00) && ((v & (v - 8'h01)) == 8'h00);
  endfunction

  // ----------------------------------------------------------------
  // Mode capture and voltage flag
  // ----------------------------------------------------------------
  // Pins are sampled every reset cycle so the last value before release sticks
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      if ({mode_pin_upper, mode_pin_lower} == 2'b00) begin
        pins_q <= {aux_mode_pin_1, aux_mode_pin_0};
        mode_q <= decode_mode({aux_mode_pin_1, aux_mode_pin_0});
        boot_q <= aux_mode_pin_2;
      end else begin
        pins_q <= {mode_pin_upper, mode_pin_lower};
        mode_q <= decode_mode({mode_pin_upper, mode_pin_lower});
        boot_q <= 1'b0;
      end
    end
  end

  // Comparator output already settled to the clock; one flop aligns it
  always_ff @(posedge clock) begin
    if (!rst_n) vpp_q <= 1'b0;
    else vpp_q <= program_voltage_pin;
  end

  assign expanded    = (mode_q != MODE_SINGLE) || expanded_mode_enable_q;
  assign rom_enabled = (mode_q != MODE_EXP_NOROM);
  assign boot_mode   = boot_q;
  assign mode_control_register_rd     = {expanded_mode_enable_q, MODE_CONTROL_REGISTER_FIXED, pins_q};

  // ----------------------------------------------------------------
  // Bus access: request taken in state one, answered in state two
  // ----------------------------------------------------------------
  assign take      = (state_q == S_IDLE) && (cpu_req.rd || cpu_req.wr);
  assign bad_align = !cpu_req.byte_acc && cpu_req.addr[0];
  assign region_d  = decode_region(cpu_req.addr, mode_q, expanded, vpp_q);
  assign wbyte     = from_lane(cpu_req.addr, cpu_req.wdata);
  assign array_addr = cpu_req.addr;
  assign ctrl_rd   = {vpp_q, ctrl_q[6:0]};

  always_comb begin
    case (region_d)
      RG_ROM:      rdata_d = array_rdata;
      RG_REG:      rdata_d = to_lane(cpu_req.addr, cpu_req.addr == CTRL_ADDR ? ctrl_rd : blk_q);
      RG_MODE_CONTROL_REGISTER:     rdata_d = to_lane(cpu_req.addr, mode_control_register_rd);
      RG_RESERVED: rdata_d = RESERVED_WORD;
      default:     rdata_d = 16'h0000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q   <= S_IDLE;
      region_q  <= RG_EXTERNAL;
      cpu_rdata <= 16'h0000;
      refused_q <= 1'b0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (take) begin
            state_q   <= S_DATA;
            region_q  <= region_d;
            refused_q <= bad_align;
            cpu_rdata <= bad_align ? 16'h0000 : rdata_d;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  assign cpu_ready   = (state_q == S_DATA);
  assign cpu_refused = cpu_ready && refused_q;
  assign ext_access  = cpu_ready && !refused_q && (region_q == RG_EXTERNAL);

  // ----------------------------------------------------------------
  // Control and block-select registers
  // ----------------------------------------------------------------
  assign ctrl_wr = take && cpu_req.wr && !bad_align && region_d == RG_REG && cpu_req.addr == CTRL_ADDR;
  assign blk_wr  = take && cpu_req.wr && !bad_align && region_d == RG_REG && cpu_req.addr == BLOCK_SEL_ADDR;
  assign ctrl_nxt = ctrl_wr ? ((wbyte & CTRL_WMASK) | (ctrl_q & ~CTRL_WMASK)) : ctrl_q;
  assign blk_nxt  = blk_wr ? wbyte : blk_q;

  // Program and erase together, or erase over several blocks, trips error protect
  assign err_set = (ctrl_nxt[CTRL_P_BIT] && ctrl_nxt[CTRL_E_BIT]) ||
                   (ctrl_nxt[CTRL_E_BIT] && !one_hot8(blk_nxt));

  // Losing the high voltage returns the register to reset, dropping P and E
  always_ff @(posedge clock) begin
    if (!rst_n || !vpp_q) begin
      ctrl_q <= CTRL_RESET;
    end else if (err_set) begin
      ctrl_q <= ctrl_nxt;
      ctrl_q[CTRL_ERR_BIT] <= 1'b1;
      ctrl_q[CTRL_P_BIT]   <= 1'b0;
      ctrl_q[CTRL_E_BIT]   <= 1'b0;
    end else begin
      ctrl_q <= ctrl_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n || !vpp_q) blk_q <= BLOCK_SEL_RESET;
    else blk_q <= blk_nxt;
  end

  // Expanded enable can only change in boot mode
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      expanded_mode_enable_q <= 1'b0;
    end else if (take && cpu_req.wr && !bad_align && region_d == RG_MODE_CONTROL_REGISTER && boot_q) begin
      expanded_mode_enable_q <= wbyte[MODE_CONTROL_REGISTER_EXPANDED_MODE_ENABLE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Protection and operation outputs
  // ----------------------------------------------------------------
  assign protect = hw_protect || ctrl_q[CTRL_SWPROT_BIT] || ctrl_q[CTRL_ERR_BIT] ||
                   !vpp_q || !rom_enabled;

  always_ff @(posedge clock) begin
    if (!rst_n || protect) begin
      op_q        <= '0;
      erase_blk_q <= BLOCK_SEL_RESET;
    end else begin
      op_q.prog         <= ctrl_q[CTRL_P_BIT];
      op_q.erase        <= ctrl_q[CTRL_E_BIT];
      op_q.prog_verify  <= ctrl_q[CTRL_PV_BIT];
      op_q.erase_verify <= ctrl_q[CTRL_EV_BIT];
      erase_blk_q       <= blk_q;
    end
  end

  assign flash_op     = op_q;
  assign erase_blocks = erase_blk_q;

  // ----------------------------------------------------------------
  // Program unit buffer
  // ----------------------------------------------------------------
  // Loads are refused while a program pulse runs so the unit stays stable
  assign buf_wr = take && cpu_req.wr && !bad_align && region_d == RG_ROM && vpp_q && !ctrl_q[CTRL_P_BIT];
  assign buf_be = cpu_req.byte_acc ? (cpu_req.addr[0] ? 2'b01 : 2'b10) : 2'b11;

  always_ff @(posedge clock) begin
    if (!rst_n) row_q <= 11'h000;
    else if (buf_wr) row_q <= cpu_req.addr[15:5];
  end

  assign prog_row = row_q;

  flash_page_buffer u_buf (
    .clock   (clock),
    .wr_en   (buf_wr),
    .wr_idx  (cpu_req.addr[4:1]),
    .wr_be   (buf_be),
    .wr_data (cpu_req.wdata),
    .rd_idx  (buf_rd_idx),
    .rd_data (buf_rd_data)
  );

  serial_boot_link u_link (
    .clock      (clock),
    .rst_n      (rst_n),
    .enable     (boot_q),
    .rx         (serial1_rx_pin),
    .tx         (serial1_tx_pin),
    .bit_period (),
    .locked     (baud_locked)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_ctrl_reset_value;
    @(posedge clock) disable iff (!rst_n) $rose(vpp_q) |-> ctrl_rd == CTRL_RESET;
  endproperty
  a_ctrl_reset_value: assert property (p_ctrl_reset_value) else $error("control not at reset value");

  property p_reserved_ff;
    @(posedge clock) disable iff (!rst_n)
      take && cpu_req.rd && !bad_align && cpu_req.addr == CTRL_ADDR && !expanded && !vpp_q
      |=> cpu_rdata == RESERVED_WORD;
  endproperty
  a_reserved_ff: assert property (p_reserved_ff) else $error("reserved read not all ones");

  property p_two_states;
    @(posedge clock) disable iff (!rst_n) take |=> cpu_ready ##1 !cpu_ready;
  endproperty
  a_two_states: assert property (p_two_states) else $error("access not two states");

  property p_odd_word_refused;
    @(posedge clock) disable iff (!rst_n) take && bad_align |=> cpu_refused && !ext_access;
  endproperty
  a_odd_word_refused: assert property (p_odd_word_refused) else $error("odd word not refused");

  property p_mode1_no_rom;
    @(posedge clock) disable iff (!rst_n) mode_q == MODE_EXP_NOROM |-> !rom_enabled && flash_op == '0;
  endproperty
  a_mode1_no_rom: assert property (p_mode1_no_rom) else $error("rom enabled in mode one");

  property p_single_block;
    @(posedge clock) disable iff (!rst_n) flash_op.erase |-> one_hot8(erase_blocks) && !flash_op.prog;
  endproperty
  a_single_block: assert property (p_single_block) else $error("erase over several blocks");

  property p_protect_blocks;
    @(posedge clock) disable iff (!rst_n) protect |=> flash_op == '0;
  endproperty
  a_protect_blocks: assert property (p_protect_blocks) else $error("operation under protection");

  property p_window_external;
    @(posedge clock) disable iff (!rst_n)
      take && !bad_align && cpu_req.addr == CTRL_ADDR && mode_q == MODE_EXP_ROM && !vpp_q |=> ext_access;
  endproperty
  a_window_external: assert property (p_window_external) else $error("window not external");

  property p_no_vpp_idle;
    @(posedge clock) disable iff (!rst_n) !vpp_q ##1 !vpp_q |-> ctrl_rd == 8'h00 && flash_op == '0;
  endproperty
  a_no_vpp_idle: assert property (p_no_vpp_idle) else $error("control live without voltage");

endmodule

// >>> host_model.sv
// Far-side model: programming-voltage source and boot serial host.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/1ps
module host_model (
  input  wire logic clock,
  output logic      vpp,
  output logic      rx
);
  // Source starts at supply level; serial line idles high
  initial begin
    vpp = 1'b0;
    rx  = 1'b1;
  end
  // Switch the voltage, then hold off reads for the setup time;
  // after release that is 50 us, i.e. 12500 cycles at 4 ns
  task automatic set_vpp(input logic on);
    vpp = on;
    repeat (on ? 20 : 12500) @(posedge clock);
    #1;
  endtask
  // Sync byte sent LSB first: eight bit times low, then high
  task automatic send_sync(input int t);
    rx = 1'b0;
    repeat (8 * t) @(posedge clock);
    #1;
    rx = 1'b1;
  endtask
endmodule

// >>> flash_rom_access_test.sv
// Self-checking bench for the flash access block.
// Assumes host_model for voltage and serial host; bench acts as the CPU.
`timescale 1ns/1ps
module flash_rom_access_test
  import flash_ctl_pkg::*;
;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  cpu_req_s    req   = '0;
  logic [1:0]  mp    = 2'b11;
  logic [2:0]  aux   = 3'b000;
  logic        hwp   = 1'b0;
  logic [3:0]  bidx  = 4'h0;
  logic [15:0] rdata, aaddr, bdata, got;
  logic        ready, refd, ext, vpp, rx, tx, lock, romen, boot, gref, gext;
  flash_op_s   op;
  logic [7:0]  eblk;
  logic [10:0] row;
  int          err_total  = 0;
  int          n_compared = 0;
  int          n;

  host_model host (.clock(clock), .vpp(vpp), .rx(rx));
  // Array word depends on address so lane slips show up
  flash_rom_access DUT (
    .clock(clock), .rst_n(rst_n), .cpu_req(req), .cpu_rdata(rdata),
    .cpu_ready(ready), .cpu_refused(refd), .ext_access(ext),
    .mode_pin_upper(mp[1]), .mode_pin_lower(mp[0]), .aux_mode_pin_2(aux[2]),
    .aux_mode_pin_1(aux[1]), .aux_mode_pin_0(aux[0]), .program_voltage_pin(vpp),
    .hw_protect(hwp), .array_addr(aaddr), .array_rdata(aaddr ^ 16'hA55A),
    .flash_op(op), .erase_blocks(eblk), .prog_row(row), .buf_rd_idx(bidx),
    .buf_rd_data(bdata), .rom_enabled(romen), .boot_mode(boot),
    .serial1_rx_pin(rx), .serial1_tx_pin(tx), .baud_locked(lock));

  // Clock of 4 ns period
  always #2 clock = ~clock;

  task automatic tick;
    @(posedge clock);
    #1;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One request, held until the edge that samples the answer; an idle
  // cycle follows so a second call never rewrites req in the same step
  task automatic bus(input logic w, input logic b, input logic [15:0] a, input logic [15:0] d);
    req = '{addr: a, wdata: d, rd: !w, wr: w, byte_acc: b};
    tick();
    chk("ready", 16'h1, {15'h0, ready});
    got  = rdata;
    gref = refd;
    gext = ext;
    tick();
    {req.rd, req.wr} = 2'b00;
    tick();
  endtask

  task automatic do_reset(input logic [1:0] m, input logic [2:0] x);
    mp    = m;
    aux   = x;
    rst_n = 1'b0;
    repeat (4) tick();
    rst_n = 1'b1;
  endtask

  task automatic t_reserved;
    bus(1'b1, 1'b1, CTRL_ADDR, 16'h0100);
    bus(1'b0, 1'b1, CTRL_ADDR, 16'h0000);
    chk("reserved", RESERVED_WORD, got);
    chk("vpp_seen", 16'h0, {15'h0, got[15:8] != 8'hFF});
  endtask

  // Each operating mode alone, with pulses kept short
  task automatic t_modes;
    host.set_vpp(1'b1);
    bus(1'b0, 1'b1, CTRL_ADDR, 16'h0000);
    chk("ctrl_reset", 16'h8000, got);
    bus(1'b1, 1'b1, BLOCK_SEL_ADDR, 16'h0100);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 1'b1, CTRL_ADDR, {8'h01 << i, 8'h00});
      tick();
      chk("op", 16'h8 >> i, {12'h0, op});
      if (i == 1) chk("blocks", 16'h0001, {8'h0, eblk});
      bus(1'b0, 1'b1, CTRL_ADDR, 16'h0000);
      chk("ctrl_rd", {8'h80 | (8'h01 << i), 8'h00}, got);
      bus(1'b1, 1'b1, CTRL_ADDR, 16'h0000);
    end
  endtask

  task automatic t_buffer;
    bus(1'b1, 1'b0, 16'h0124, 16'h1234);
    bidx = 4'h2;
    repeat (2) tick();
    chk("buf", 16'h1234, bdata);
    chk("row", 16'h0009, {5'h0, row});
  endtask

  // Software, hardware and error protection each hold the array idle
  task automatic t_protect;
    bus(1'b1, 1'b1, CTRL_ADDR, 16'h4100);
    tick();
    chk("sw_prot", 16'h0, {12'h0, op});
    bus(1'b1, 1'b1, CTRL_ADDR, 16'h0000);
    hwp = 1'b1;
    bus(1'b1, 1'b1, CTRL_ADDR, 16'h0100);
    tick();
    chk("hw_prot", 16'h0, {12'h0, op});
    hwp = 1'b0;
    bus(1'b1, 1'b1, CTRL_ADDR, 16'h0000);
    bus(1'b1, 1'b1, BLOCK_SEL_ADDR, 16'h0300);
    bus(1'b1, 1'b1, CTRL_ADDR, 16'h0200);
    tick();
    chk("err_prot", 16'h0, {12'h0, op});
    bus(1'b0, 1'b1, CTRL_ADDR, 16'h0000);
    chk("err_bit", 16'h2000, got & 16'h2000);
  endtask

  task automatic t_lanes;
    bus(1'b0, 1'b0, 16'h0010, 16'h0000);
    chk("word", 16'hA54A, got);
    bus(1'b0, 1'b1, 16'h0010, 16'h0000);
    chk("even", 16'h00A5, {8'h0, got[15:8]});
    bus(1'b0, 1'b1, 16'h0011, 16'h0000);
    chk("odd", 16'h004B, {8'h0, got[7:0]});
    bus(1'b0, 1'b0, 16'h0011, 16'h0000);
    chk("odd_word", 16'h0001, {15'h0, gref});
    chk("odd_data", 16'h0000, got);
  endtask

  // Mode pins are only taken in reset, so each case resets
  task automatic t_pins;
    host.set_vpp(1'b0);
    do_reset(2'b10, 3'b000);
    bus(1'b0, 1'b1, CTRL_ADDR, 16'h0000);
    chk("external", 16'h1, {15'h0, gext});
    chk("ext_data", 16'h0000, got);
    chk("rom_m2", 16'h1, {15'h0, romen});
    do_reset(2'b01, 3'b000);
    chk("rom_m1", 16'h0, {15'h0, romen});
  endtask

  // Host bit time of 16 cycles; answer is nine bit times low
  task automatic t_boot;
    do_reset(2'b00, 3'b100);
    chk("boot", 16'h1, {15'h0, boot});
    bus(1'b1, 1'b1, MODE_CTRL_ADDR, 16'h0080);
    bus(1'b0, 1'b1, MODE_CTRL_ADDR, 16'h0000);
    chk("mode_control_register", {8'h00, 1'b1, MODE_CONTROL_REGISTER_FIXED, 2'b00}, got);
    host.send_sync(16);
    n = 0;
    while (tx === 1'b1 && n < 400) begin
      tick();
      n++;
    end
    chk("locked", 16'h1, {15'h0, lock});
    n = 0;
    while (tx === 1'b0 && n < 400) begin
      tick();
      n++;
    end
    chk("tx_low", 16'h1, {15'h0, n >= 142 && n <= 146});
  endtask

  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    #1;
    do_reset(2'b11, 3'b000);
    t_reserved();
    t_modes();
    t_buffer();
    t_protect();
    t_lanes();
    t_pins();
    t_boot();
    report_and_stop();
  end

  // Watchdog well beyond the expected thirteen thousand cycles
  initial begin
    #200000;
    err_total++;
    report_and_stop();
  end
endmodule
